// ==== core/ddr2_controller_end.sv ====
// controller end: queues one request and issues it once every spacing is met, but drops a read of a bank flagged for rewrite
// assumes the memory end samples the link on the next rising edge of clk_sys
//
// How it works
// (RULE_01) auto-precharge recovery is write count plus precharge
// (RULE_02) write count comes from mode register field
// (RULE_03) clock change only in self-refresh or power-down
// (RULE_04) mode bit ten picks single or differential strobe
// (RULE_05) at least two clocks from write to read
// (RULE_06) clock enable holds for three sampled edges
// (RULE_07) badly timed write must be rewritten before reading
// (RULE_08) nanosecond times become rounded-up cycle counts
// (RULE_09) activate allowed two cycles after power-down exit
// (RULE_10) down-counters block dependent commands until zero
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_consts.svh"

module ddr2_controller_end
  import ddr2_timing_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            rst_b,
  ddr2_link_if.controller                      link,
  input  wire logic                            req_valid,
  input  wire cmd_t                            req_cmd,
  input  wire logic [`BANK_WIDTH-1:0]          req_bank,
  input  wire logic [`MODE_REGISTER_WIDTH-1:0] req_addr,
  input  wire logic                            req_wdata_timing_ok,
  output logic                                 req_ready,
  input  wire logic                            pdn_req,
  input  wire logic                            sref_req,
  output logic                                 freq_change_grant,
  output logic                                 read_refused,
  output logic [`BANK_COUNT-1:0]               rewrite_needed,
  output logic [`COUNT_WIDTH-1:0]              autoprecharge_write_recovery_interval
);
  localparam logic [`COUNT_WIDTH-1:0] RP_NCK =
    round_up_cycles(`ROW_PRECHARGE_TIME_PS, `CLK_PERIOD_PS); // [RULE_08]

  typedef struct packed {
    logic                            cke;
    cmd_t                            cmd;
    logic [`BANK_WIDTH-1:0]          bank;
    logic [`MODE_REGISTER_WIDTH-1:0] addr;
    logic                            wdok;
    pwr_state_t                      pwr;
    logic [1:0]                      cke_hold;
    logic [`COUNT_WIDTH-1:0]         act_wait;
    logic [`COUNT_WIDTH-1:0]         rd_wait;
    logic [`MODE_WRITE_RECOVERY_WIDTH-1:0] wr_count;
    logic [`COUNT_WIDTH-1:0]         dal;
    logic [`BANK_COUNT-1:0]          poisoned;
    logic                            pend_valid;
    cmd_t                            pend_cmd;
    logic [`BANK_WIDTH-1:0]          pend_bank;
    logic [`MODE_REGISTER_WIDTH-1:0] pend_addr;
    logic                            pend_wdok;
    logic                            ready;
    logic                            grant;
    logic                            refused;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;
  logic       issue_ok;

  // ****************************************
  // legality of the pending command
  // ****************************************
  always_comb
  begin
    issue_ok = 1'b0;
    if (st.pend_valid && st.pwr == PWR_ACTIVE && st.cke)
    begin
      case (st.pend_cmd)
        CMD_ACT:
        begin
          issue_ok = (st.act_wait == '0); // [RULE_09] [RULE_10]
        end
        CMD_RD:
        begin
          issue_ok = (st.rd_wait == '0); // [RULE_05] [RULE_10]
        end
        default:
        begin
          issue_ok = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st         = st;
    next_st.cmd     = CMD_NOP;
    next_st.refused = 1'b0;
    if (st.act_wait != '0)
    begin
      next_st.act_wait = st.act_wait - 1'b1; // [RULE_10]
    end
    if (st.rd_wait != '0)
    begin
      next_st.rd_wait = st.rd_wait - 1'b1; // [RULE_10]
    end
    if (st.cke_hold != 2'h0)
    begin
      next_st.cke_hold = st.cke_hold - 2'h1;
    end
    if (req_valid && st.ready)
    begin
      next_st.pend_valid = 1'b1;
      next_st.pend_cmd   = req_cmd;
      next_st.pend_bank  = req_bank;
      next_st.pend_addr  = req_addr;
      next_st.pend_wdok  = req_wdata_timing_ok;
    end
    case (st.pwr)
      PWR_ACTIVE:
      begin
        if (issue_ok)
        begin
          next_st.pend_valid = 1'b0;
          next_st.bank       = st.pend_bank;
          next_st.addr       = st.pend_addr;
          next_st.wdok       = st.pend_wdok;
          if (st.pend_cmd == CMD_RD && st.poisoned[st.pend_bank])
          begin
            // dropped rather than held, so a missing rewrite cannot wedge the queue
            next_st.refused = 1'b1; // [RULE_07]
          end
          else
          begin
            next_st.cmd = st.pend_cmd;
          end
          case (st.pend_cmd)
            CMD_PRE:
            begin
              if (next_st.act_wait < RP_NCK - 1'b1)
              begin
                next_st.act_wait = RP_NCK - 1'b1; // [RULE_08] [RULE_10]
              end
            end
            CMD_WR, CMD_WRA:
            begin
              next_st.rd_wait = `COUNT_WIDTH'(`WRITE_TO_READ_TURNAROUND_NCK - 1); // [RULE_05]
              next_st.poisoned[st.pend_bank] = !st.pend_wdok; // [RULE_07]
              if (st.pend_cmd == CMD_WRA && next_st.act_wait < st.dal - 1'b1)
              begin
                next_st.act_wait = st.dal - 1'b1; // [RULE_01] [RULE_10]
              end
            end
            CMD_MRS:
            begin
              next_st.wr_count =
                st.pend_addr[`MODE_WRITE_RECOVERY_LSB +: `MODE_WRITE_RECOVERY_WIDTH]; // [RULE_02]
            end
            default:
            begin
            end
          endcase
        end
        else if ((pdn_req || sref_req) && !st.pend_valid && st.cke_hold == 2'h0
                 && st.act_wait == '0 && st.rd_wait == '0)
        begin
          next_st.cke      = 1'b0;
          next_st.cmd      = sref_req ? CMD_REF : CMD_NOP;
          next_st.pwr      = sref_req ? PWR_SELF : PWR_PDN;
          next_st.cke_hold = 2'(`CLOCK_ENABLE_MIN_PULSE_NCK - 1); // [RULE_06]
        end
      end
      PWR_PDN:
      begin
        if (!pdn_req && st.cke_hold == 2'h0)
        begin
          next_st.cke      = 1'b1;
          next_st.pwr      = PWR_ACTIVE;
          next_st.cke_hold = 2'(`CLOCK_ENABLE_MIN_PULSE_NCK - 1); // [RULE_06]
          next_st.act_wait = `COUNT_WIDTH'(`POWERDOWN_EXIT_TO_ACTIVATE_NCK - 1); // [RULE_09]
        end
      end
      default:
      begin
        if (!sref_req && st.cke_hold == 2'h0)
        begin
          next_st.cke      = 1'b1;
          next_st.pwr      = PWR_ACTIVE;
          next_st.cke_hold = 2'(`CLOCK_ENABLE_MIN_PULSE_NCK - 1); // [RULE_06]
          next_st.act_wait = `COUNT_WIDTH'(`POWERDOWN_EXIT_TO_ACTIVATE_NCK - 1); // [RULE_09]
        end
      end
    endcase
    next_st.dal   = `COUNT_WIDTH'(next_st.wr_count) + RP_NCK; // [RULE_01]
    next_st.ready = !next_st.pend_valid;
    // grant only once the low clock enable has been seen three times
    next_st.grant = (next_st.pwr != PWR_ACTIVE) && !next_st.cke
                    && (next_st.cke_hold == 2'h0); // [RULE_03]
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st          <= '0;
      st.cke      <= 1'b1;
      st.cmd      <= CMD_NOP;
      st.pend_cmd <= CMD_NOP;
      st.pwr      <= PWR_ACTIVE;
      st.dal      <= RP_NCK;
      st.ready    <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.cke                               = st.cke;
  assign link.cmd                               = st.cmd;
  assign link.bank                              = st.bank;
  assign link.addr                              = st.addr;
  assign link.wdata_timing_ok                   = st.wdok;
  assign req_ready                              = st.ready;
  assign freq_change_grant                      = st.grant;
  assign read_refused                           = st.refused;
  assign rewrite_needed                         = st.poisoned;
  assign autoprecharge_write_recovery_interval  = st.dal;
endmodule

`default_nettype wire

// ==== core/ddr2_timing_consts.svh ====
// timing counts, mode register field positions and reset values for both link ends
// assumes both ends run on the same 250 MHz clk_sys
`ifndef DDR2_TIMING_CONSTS_SVH
`define DDR2_TIMING_CONSTS_SVH

// ****************************************
// clock and nanosecond parameters
// ****************************************
`define CLK_PERIOD_PS                   4000
`define ROW_PRECHARGE_TIME_PS           15000

// ****************************************
// fixed clock counts
// ****************************************
`define WRITE_TO_READ_TURNAROUND_NCK    2
`define POWERDOWN_EXIT_TO_ACTIVATE_NCK  2
`define CLOCK_ENABLE_MIN_PULSE_NCK      3

// ****************************************
// mode register layout
// ****************************************
`define MODE_REGISTER_WIDTH             13
`define MODE_REGISTER_RESET             13'h0000
`define MODE_STROBE_SELECT_BIT          10
`define MODE_WRITE_RECOVERY_LSB         0
`define MODE_WRITE_RECOVERY_WIDTH       3
`define BANK_COUNT                      8
`define BANK_WIDTH                      3
`define COUNT_WIDTH                     8

`endif

// ==== core/ddr2_timing_pkg.sv ====
// command and power state types plus the shared round-up arithmetic
// assumes ddr2_timing_consts.svh is on the include path
`include "ddr2_timing_consts.svh"

package ddr2_timing_pkg;

  typedef enum logic [2:0]
  {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_WRA = 3'h4,
    CMD_PRE = 3'h5,
    CMD_MRS = 3'h6,
    CMD_REF = 3'h7
  } cmd_t;

  typedef enum logic [2:0]
  {
    PWR_ACTIVE = 3'h1,
    PWR_PDN    = 3'h2,
    PWR_SELF   = 3'h4
  } pwr_state_t;

  // whole clock count for a time, rounded up, never below one
  function automatic logic [`COUNT_WIDTH-1:0] round_up_cycles(input int unsigned time_ps,
                                                              input int unsigned period_ps);
    int unsigned q;
    q = (time_ps + period_ps - 1) / period_ps;
    if (q == 0)
    begin
      q = 1;
    end
    return q[`COUNT_WIDTH-1:0];
  endfunction

endpackage

// ==== core/ddr2_link_if.sv ====
// command link between the controller end and the memory end
// assumes both ends share clk_sys; commands are taken on its rising edge
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_consts.svh"

interface ddr2_link_if
  import ddr2_timing_pkg::*;
(
  input wire logic clk_sys
);
  logic                            cke;
  cmd_t                            cmd;
  logic [`BANK_WIDTH-1:0]          bank;
  logic [`MODE_REGISTER_WIDTH-1:0] addr;
  logic                            wdata_timing_ok;

  modport controller
  (
    output cke,
    output cmd,
    output bank,
    output addr,
    output wdata_timing_ok
  );

  modport memory
  (
    input  cke,
    input  cmd,
    input  bank,
    input  addr,
    input  wdata_timing_ok
  );
endinterface

`default_nettype wire

// ==== core/ddr2_memory_end.sv ====
// memory end: holds the mode register and checks the spacing it is given
// assumes the controller end drives the link from flops on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_consts.svh"

module ddr2_memory_end
  import ddr2_timing_pkg::*;
(
  input  wire logic                           clk_sys,
  input  wire logic                           rst_b,
  ddr2_link_if.memory                         link,
  output logic                                strobe_single,
  output logic [`MODE_WRITE_RECOVERY_WIDTH-1:0] write_recovery_count,
  output logic [`COUNT_WIDTH-1:0]             autoprecharge_write_recovery_interval,
  output logic                                freq_change_ok,
  output logic                                spacing_violation,
  output logic                                cke_violation,
  output logic                                read_corrupt
);
  localparam logic [`COUNT_WIDTH-1:0] RP_NCK =
    round_up_cycles(`ROW_PRECHARGE_TIME_PS, `CLK_PERIOD_PS);

  typedef struct packed {
    logic [`MODE_REGISTER_WIDTH-1:0] mode_register;
    pwr_state_t                      pwr;
    logic                            cke_q;
    logic [1:0]                      cke_run;
    logic [`COUNT_WIDTH-1:0]         act_wait;
    logic [`COUNT_WIDTH-1:0]         rd_wait;
    logic [`BANK_COUNT-1:0]          poisoned;
    logic                            strobe_single;
    logic [`MODE_WRITE_RECOVERY_WIDTH-1:0] wr_count;
    logic [`COUNT_WIDTH-1:0]         dal;
    logic                            freq_ok;
    logic                            spacing_bad;
    logic                            cke_bad;
    logic                            rd_bad;
  } mem_state_t;

  mem_state_t st;
  mem_state_t next_st;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st             = st;
    next_st.spacing_bad = 1'b0;
    next_st.cke_bad     = 1'b0;
    next_st.rd_bad      = 1'b0;
    next_st.cke_q       = link.cke;
    if (st.act_wait != '0)
    begin
      next_st.act_wait = st.act_wait - 1'b1;
    end
    if (st.rd_wait != '0)
    begin
      next_st.rd_wait = st.rd_wait - 1'b1;
    end
    // a level must be seen on three edges in a row before it may change
    if (link.cke != st.cke_q)
    begin
      next_st.cke_run = 2'h1;
      if (st.cke_run < 2'(`CLOCK_ENABLE_MIN_PULSE_NCK))
      begin
        next_st.cke_bad = 1'b1;
      end
    end
    else if (st.cke_run < 2'(`CLOCK_ENABLE_MIN_PULSE_NCK))
    begin
      next_st.cke_run = st.cke_run + 2'h1;
    end
    case (st.pwr)
      PWR_ACTIVE:
      begin
        if (!link.cke)
        begin
          next_st.pwr = (link.cmd == CMD_REF) ? PWR_SELF : PWR_PDN;
        end
        else
        begin
          case (link.cmd)
            CMD_ACT:
            begin
              // counts come from our own edges, so jitter cannot shorten them
              if (st.act_wait != '0)
              begin
                next_st.spacing_bad = 1'b1; // [RULE_08] [RULE_09]
              end
            end
            CMD_PRE:
            begin
              if (next_st.act_wait < RP_NCK - 1'b1)
              begin
                next_st.act_wait = RP_NCK - 1'b1; // [RULE_08]
              end
            end
            CMD_WR, CMD_WRA:
            begin
              next_st.rd_wait = `COUNT_WIDTH'(`WRITE_TO_READ_TURNAROUND_NCK - 1);
              next_st.poisoned[link.bank] = !link.wdata_timing_ok;
              if (link.cmd == CMD_WRA && next_st.act_wait < st.dal - 1'b1)
              begin
                next_st.act_wait = st.dal - 1'b1; // [RULE_02]
              end
            end
            CMD_RD:
            begin
              next_st.rd_bad = st.poisoned[link.bank];
              if (st.rd_wait != '0)
              begin
                next_st.spacing_bad = 1'b1;
              end
            end
            CMD_MRS:
            begin
              next_st.mode_register = link.addr;
            end
            default:
            begin
            end
          endcase
        end
      end
      default:
      begin
        if (link.cke)
        begin
          next_st.pwr      = PWR_ACTIVE;
          next_st.act_wait = `COUNT_WIDTH'(`POWERDOWN_EXIT_TO_ACTIVATE_NCK - 1); // [RULE_09]
        end
      end
    endcase
    next_st.strobe_single = next_st.mode_register[`MODE_STROBE_SELECT_BIT]; // [RULE_04]
    next_st.wr_count =
      next_st.mode_register[`MODE_WRITE_RECOVERY_LSB +: `MODE_WRITE_RECOVERY_WIDTH]; // [RULE_02]
    next_st.dal     = `COUNT_WIDTH'(next_st.wr_count) + RP_NCK; // [RULE_02]
    next_st.freq_ok = (next_st.pwr != PWR_ACTIVE);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st               <= '0;
      st.mode_register <= `MODE_REGISTER_RESET;
      st.pwr           <= PWR_ACTIVE;
      st.cke_q         <= 1'b1;
      st.cke_run       <= 2'(`CLOCK_ENABLE_MIN_PULSE_NCK);
      st.dal           <= RP_NCK;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign strobe_single                          = st.strobe_single;
  assign write_recovery_count                   = st.wr_count;
  assign autoprecharge_write_recovery_interval  = st.dal;
  assign freq_change_ok                         = st.freq_ok;
  assign spacing_violation                      = st.spacing_bad;
  assign cke_violation                          = st.cke_bad;
  assign read_corrupt                           = st.rd_bad;
endmodule

`default_nettype wire

// ==== testbench/ddr2_link_props.sv ====
// concurrent checks on the command link shared by both ends
// assumes one clk_sys domain; the bench wires the link signals in by name
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_consts.svh"

module ddr2_link_props
  import ddr2_timing_pkg::*;
(
  input wire logic                            clk_sys,
  input wire logic                            rst_b,
  input wire logic                            cke,
  input wire cmd_t                            cmd,
  input wire logic [`BANK_WIDTH-1:0]          bank,
  input wire logic [`MODE_REGISTER_WIDTH-1:0] addr,
  input wire logic                            wdata_timing_ok
);
  // ****************************************
  // link shadow state
  // ****************************************
  typedef struct packed {
    logic [7:0] dal_wait;
    logic [2:0] wr_count;
    logic [7:0] poison;
  } shadow_t;

  shadow_t shadow;
  shadow_t next_shadow;

  always_comb
  begin
    next_shadow = shadow;
    if (shadow.dal_wait != 8'h00)
      next_shadow.dal_wait = shadow.dal_wait - 8'h01;
    if (cmd == CMD_MRS)
      next_shadow.wr_count = addr[2:0];
    // one below write count plus four, so zero marks the first legal edge
    if (cmd == CMD_WRA)
      next_shadow.dal_wait = {5'h00, shadow.wr_count} + 8'h03;
    if ((cmd == CMD_WR) || (cmd == CMD_WRA))
      next_shadow.poison[bank] = ~wdata_timing_ok;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      shadow <= '0;
    else
      shadow <= next_shadow;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_wr_to_rd: assert property (cmd == CMD_WR |=> cmd != CMD_RD)
    else $error("read one cycle after write");
  a_wra_to_rd: assert property (cmd == CMD_WRA |=> cmd != CMD_RD)
    else $error("read one cycle after auto-precharge write");
  a_cke_hold: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("clock enable held under three edges");
  a_pdn_exit_act: assert property ($rose(cke) |-> cmd != CMD_ACT ##1 cmd != CMD_ACT)
    else $error("activate too soon after power-down exit");
  a_pre_to_act: assert property (cmd == CMD_PRE |=> (cmd != CMD_ACT) [*3])
    else $error("activate inside precharge time");
  a_dal_to_act: assert property (cmd == CMD_ACT |-> shadow.dal_wait == 8'h00)
    else $error("activate inside auto-precharge recovery");
  a_poison_read: assert property (cmd == CMD_RD |-> !shadow.poison[bank])
    else $error("read of bank with badly timed write");
  a_low_power_quiet: assert property (!cke |-> cmd inside {CMD_NOP, CMD_REF})
    else $error("command issued with clock enable low");

  c_wra_act: cover property (shadow.dal_wait == 8'h01 ##1 cmd == CMD_ACT);
  c_pdn_exit: cover property ($rose(cke));
  c_wr_rd: cover property (cmd == CMD_WR ##2 cmd == CMD_RD);
endmodule

`default_nettype wire

// ==== testbench/tb_ddr2_cycle_timing_rules.sv ====
// self-checking bench: both link ends joined, plus a memory end on a bench-driven link
// assumes 250 MHz clk_sys and inputs driven on its falling edge
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_consts.svh"

module tb_ddr2_cycle_timing_rules;
  import ddr2_timing_pkg::*;

  logic        clk_sys, rst_b, req_valid, req_ok, pdn_req, sref_req;
  logic        req_ready, freq_change_grant, read_refused, strobe_single, freq_change_ok;
  logic        spacing_violation, cke_violation, read_corrupt, f_spacing, f_cke, f_corrupt;
  cmd_t        req_cmd;
  logic [2:0]  req_bank, mem_wr;
  logic [12:0] req_addr;
  logic [7:0]  rewrite_needed, ctl_dal, mem_dal;
  logic        cke_prev;
  int          cyc, bad_count, num_checks, cke_up_at, n_refused, n_bad, f_sp, f_ck, f_co;
  int          at_cmd [8];

  ddr2_link_if u_ddr2_link_if (.clk_sys(clk_sys));
  ddr2_link_if u_ddr2_link_if_fault (.clk_sys(clk_sys));

  ddr2_controller_end u_ddr2_controller_end (.clk_sys(clk_sys), .rst_b(rst_b),
    .link(u_ddr2_link_if), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_addr(req_addr), .req_wdata_timing_ok(req_ok), .req_ready(req_ready),
    .pdn_req(pdn_req), .sref_req(sref_req), .freq_change_grant(freq_change_grant),
    .read_refused(read_refused), .rewrite_needed(rewrite_needed),
    .autoprecharge_write_recovery_interval(ctl_dal));

  ddr2_memory_end u_ddr2_memory_end (.clk_sys(clk_sys), .rst_b(rst_b),
    .link(u_ddr2_link_if), .strobe_single(strobe_single), .write_recovery_count(mem_wr),
    .autoprecharge_write_recovery_interval(mem_dal), .freq_change_ok(freq_change_ok),
    .spacing_violation(spacing_violation), .cke_violation(cke_violation),
    .read_corrupt(read_corrupt));

  // second memory end faces a link the bench drives, so faults can be forced
  ddr2_memory_end u_ddr2_memory_end_fault (.clk_sys(clk_sys), .rst_b(rst_b),
    .link(u_ddr2_link_if_fault), .strobe_single(), .write_recovery_count(),
    .autoprecharge_write_recovery_interval(), .freq_change_ok(),
    .spacing_violation(f_spacing), .cke_violation(f_cke), .read_corrupt(f_corrupt));

  ddr2_link_props u_ddr2_link_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .cke(u_ddr2_link_if.cke), .cmd(u_ddr2_link_if.cmd), .bank(u_ddr2_link_if.bank),
    .addr(u_ddr2_link_if.addr), .wdata_timing_ok(u_ddr2_link_if.wdata_timing_ok));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ****************************************
  // link monitor: cycle stamps and pulse tallies
  // ****************************************
  always @(negedge clk_sys)
  begin
    cyc++;
    if (u_ddr2_link_if.cmd != CMD_NOP) at_cmd[u_ddr2_link_if.cmd] = cyc;
    if (u_ddr2_link_if.cke === 1'b1 && cke_prev === 1'b0) cke_up_at = cyc;
    cke_prev = u_ddr2_link_if.cke;
    if (read_refused === 1'b1) n_refused++;
    if ((spacing_violation | cke_violation | read_corrupt) !== 1'b0) n_bad++;
    if (f_spacing === 1'b1) f_sp++;
    if (f_cke === 1'b1) f_ck++;
    if (f_corrupt === 1'b1) f_co++;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys) u_ddr2_link_if_fault.cmd = CMD_NOP;
  endtask

  task automatic send(input cmd_t c, input logic [2:0] b, input logic [12:0] a,
                      input logic ok);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_ok = ok;
    for (n = 0; req_ready !== 1'b1; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask

  task automatic fcmd(input cmd_t c, input logic ok);
    @(negedge clk_sys);
    u_ddr2_link_if_fault.cmd = c;
    u_ddr2_link_if_fault.wdata_timing_ok = ok;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_mode();
    for (int i = 0; i < 4; i++)
    begin
      send(CMD_MRS, 3'h0, {2'h0, i[0], 7'h00, i[1] ? 3'h7 : 3'h0}, 1'b1);
      idle(4);
      chk(13'(strobe_single), 13'(i[0]), "strobe select");
      chk(13'(mem_wr), i[1] ? 13'h0007 : 13'h0000, "write count");
      chk(13'(mem_dal), i[1] ? 13'h000B : 13'h0004, "memory dal");
      chk(13'(ctl_dal), i[1] ? 13'h000B : 13'h0004, "controller dal");
    end
  endtask

  task automatic t_gap(input cmd_t a, input cmd_t b, input logic [12:0] exp, input int wt);
    send(a, 3'h2, 13'h0000, 1'b1);
    send(b, 3'h2, 13'h0000, 1'b1);
    idle(wt);
    chk(13'(at_cmd[b] - at_cmd[a]), exp, "command gap");
  endtask

  task automatic t_power(input logic self);
    int n;
    @(negedge clk_sys);
    pdn_req = ~self;
    sref_req = self;
    for (n = 0; u_ddr2_link_if.cke !== 1'b0; n++) @(negedge clk_sys);
    idle(4);
    chk(13'(freq_change_grant), 13'h0001, "grant in low power");
    chk(13'(freq_change_ok), 13'h0001, "memory low power");
    send(CMD_ACT, 3'h0, 13'h0000, 1'b1);
    idle(3);
    chk(13'(req_ready), 13'h0000, "activate held while low");
    pdn_req = 1'b0;
    sref_req = 1'b0;
    idle(8);
    chk(13'(at_cmd[CMD_ACT] - cke_up_at), 13'h0002, "exit to activate");
    chk(13'(freq_change_grant), 13'h0000, "grant after exit");
  endtask

  task automatic t_poison();
    int t0;
    int r0;
    send(CMD_WR, 3'h2, 13'h0000, 1'b0);
    idle(4);
    chk(13'(rewrite_needed), 13'h0004, "bank flagged");
    t0 = at_cmd[CMD_RD];
    r0 = n_refused;
    send(CMD_RD, 3'h2, 13'h0000, 1'b1);
    idle(4);
    chk(13'(at_cmd[CMD_RD] - t0), 13'h0000, "poisoned read kept off");
    chk(13'(n_refused - r0), 13'h0001, "read refused");
    t_gap(CMD_WR, CMD_RD, 13'h0002, 6);
    chk(13'(rewrite_needed), 13'h0000, "flag cleared");
  endtask

  task automatic t_pair(input cmd_t a, input cmd_t b, input int gap, input logic ok,
                        input logic [12:0] exp_sp, input logic [12:0] exp_co);
    int s0;
    int c0;
    s0 = f_sp;
    c0 = f_co;
    fcmd(a, ok);
    idle(gap - 1);
    fcmd(b, 1'b1);
    idle(3);
    chk(13'(f_sp - s0), exp_sp, "fault spacing flag");
    chk(13'(f_co - c0), exp_co, "fault corrupt flag");
  endtask

  task automatic t_cke(input int low, input int gap, input logic [12:0] exp_ck,
                       input logic [12:0] exp_sp);
    int k0;
    int s0;
    k0 = f_ck;
    s0 = f_sp;
    @(negedge clk_sys);
    u_ddr2_link_if_fault.cke = 1'b0;
    idle(low - 1);
    @(negedge clk_sys);
    u_ddr2_link_if_fault.cke = 1'b1;
    idle(gap - 1);
    fcmd(CMD_ACT, 1'b1);
    idle(4);
    chk(13'(f_ck - k0), exp_ck, "fault cke flag");
    chk(13'(f_sp - s0), exp_sp, "fault exit spacing");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    {rst_b, req_valid, req_ok, pdn_req, sref_req, cke_prev} = 6'h01;
    req_cmd = CMD_NOP;
    {req_bank, req_addr} = 16'h0000;
    u_ddr2_link_if_fault.cke = 1'b1;
    u_ddr2_link_if_fault.cmd = CMD_NOP;
    u_ddr2_link_if_fault.bank = 3'h3;
    u_ddr2_link_if_fault.addr = 13'h0000;
    u_ddr2_link_if_fault.wdata_timing_ok = 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    t_mode();
    t_gap(CMD_WR, CMD_RD, 13'h0002, 6);
    t_gap(CMD_PRE, CMD_ACT, 13'h0004, 8);
    t_gap(CMD_WRA, CMD_ACT, 13'h000B, 14);
    t_power(1'b0);
    t_power(1'b1);
    t_poison();
    t_pair(CMD_WR, CMD_RD, 1, 1'b1, 13'h0001, 13'h0000);
    t_pair(CMD_WR, CMD_RD, 2, 1'b1, 13'h0000, 13'h0000);
    t_pair(CMD_PRE, CMD_ACT, 3, 1'b1, 13'h0001, 13'h0000);
    t_pair(CMD_PRE, CMD_ACT, 4, 1'b1, 13'h0000, 13'h0000);
    t_pair(CMD_WRA, CMD_ACT, 3, 1'b1, 13'h0001, 13'h0000);
    t_pair(CMD_WRA, CMD_ACT, 4, 1'b1, 13'h0000, 13'h0000);
    t_pair(CMD_WR, CMD_RD, 2, 1'b0, 13'h0000, 13'h0001);
    t_pair(CMD_WR, CMD_RD, 2, 1'b1, 13'h0000, 13'h0000);
    t_cke(1, 2, 13'h0001, 13'h0000);
    t_cke(3, 1, 13'h0000, 13'h0001);
    t_cke(3, 2, 13'h0000, 13'h0000);
    chk(13'(n_bad), 13'h0000, "memory end flagged");
    give_verdict();
  end

  initial
  begin
    #20000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule

`default_nettype wire
